// ---- design/sfia_apb_slave.sv ----
`timescale 1ns/1ps
module sfia_apb_slave (
  input wire logic pclk,
  input wire logic presetn,
  input sfia_pkg::sfia_apb_req_t apb_req,
  output sfia_pkg::sfia_apb_rsp_t apb_rsp,
  input wire logic addr_hit,
  input wire logic [sfia_pkg::DATA_W-1:0] read_value,
  output logic commit
);
  import sfia_pkg::*;

  typedef struct packed {
    sfia_apb_rsp_t rsp;
  } sfia_slv_state_t;

  sfia_slv_state_t st;
  sfia_slv_state_t next_st;
  logic setup;

  // ---------------------------------------------------------------
  // One wait-free access phase: the answer is prepared in setup.
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    setup = apb_req.psel & ~apb_req.penable;
    next_st.rsp.pready = setup;
    next_st.rsp.pslverr = setup & ~addr_hit;
    if (setup) begin
      next_st.rsp.prdata = (~apb_req.pwrite & addr_hit) ? read_value : DATA_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign apb_rsp = st.rsp;
  assign commit = apb_req.psel & apb_req.penable & st.rsp.pready & ~st.rsp.pslverr;

endmodule

// ---- design/sfia_fabric_port.sv ----
`timescale 1ns/1ps
module sfia_fabric_port (
  input wire logic pclk,
  input wire logic presetn,
  input sfia_pkg::sfia_fab_req_t launch,
  output sfia_pkg::sfia_fab_req_t fab_req,
  input sfia_pkg::sfia_fab_rsp_t fab_rsp,
  output logic done,
  output logic [sfia_pkg::DATA_W-1:0] read_data
);
  import sfia_pkg::*;

  typedef struct packed {
    sfia_fab_req_t req;
    logic done;
    logic [DATA_W-1:0] rdata;
  } sfia_port_state_t;

  sfia_port_state_t st;
  sfia_port_state_t next_st;

  // ---------------------------------------------------------------
  // Request holds until the fabric acknowledges it.
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (st.req.valid && fab_rsp.ack) begin
      next_st.req.valid = 1'b0;
      next_st.done = 1'b1;
      if (!st.req.write) begin
        next_st.rdata = fab_rsp.rdata;
      end
    end else if (launch.valid && !st.req.valid) begin
      next_st.req = launch;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign fab_req = st.req;
  assign done = st.done;
  assign read_data = st.rdata;

endmodule

// ---- design/sfia_pkg.sv ----
package sfia_pkg;

  // ---------------------------------------------------------------
  // Register map and field layout
  // ---------------------------------------------------------------
  localparam int APB_ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int TADDR_W = 16;
  localparam int BE_W = 4;

  localparam logic [APB_ADDR_W-1:0] OFF_DATA = 12'h1AC;
  localparam logic [APB_ADDR_W-1:0] OFF_COMMAND = 12'h1B0;

  localparam int BUSY_BIT = 31;
  localparam int DIR_BIT = 30;
  localparam int STEP_UP_BIT = 29;
  localparam int STEP_DOWN_BIT = 28;
  localparam int BE_LSB = 16;
  localparam int TADDR_LSB = 0;

  // ---------------------------------------------------------------
  // Reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [BE_W-1:0] BE_RST = 4'h0;
  localparam logic [TADDR_W-1:0] TADDR_RST = 16'h0000;
  localparam logic [TADDR_W-1:0] TADDR_ONE = 16'h0001;
  localparam logic FLAG_RST = 1'b0;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;

  typedef enum logic [1:0] {
    STEP_NONE = 2'b00,
    STEP_UP = 2'b01,
    STEP_DOWN = 2'b10
  } sfia_step_t;

  typedef enum logic {
    ENG_IDLE = 1'b0,
    ENG_BUSY = 1'b1
  } sfia_eng_t;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_DATA = 2'b01,
    SEL_COMMAND = 2'b10
  } sfia_sel_t;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [BE_W-1:0] pstrb;
  } sfia_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } sfia_apb_rsp_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [TADDR_W-1:0] addr;
    logic [BE_W-1:0] be;
    logic [DATA_W-1:0] wdata;
  } sfia_fab_req_t;

  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] rdata;
  } sfia_fab_rsp_t;

endpackage

// ---- design/sfia_top.sv ----
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module sfia_top (
  input wire logic pclk,
  input wire logic presetn,
  input sfia_pkg::sfia_apb_req_t apb_req,
  output sfia_pkg::sfia_apb_rsp_t apb_rsp,
  output sfia_pkg::sfia_fab_req_t fab_req,
  input sfia_pkg::sfia_fab_rsp_t fab_rsp
);
  import sfia_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] host_value;
    logic [DATA_W-1:0] fabric_value;
    sfia_eng_t eng;
    logic direction_select;
    logic address_step_up;
    logic address_step_down;
    logic [BE_W-1:0] byte_lane_enables;
    logic [TADDR_W-1:0] target_address;
    sfia_step_t pending_step;
  } sfia_top_state_t;

  sfia_top_state_t st;
  sfia_top_state_t next_st;
  sfia_fab_req_t launch;
  sfia_sel_t sel;
  logic addr_hit;
  logic commit;
  logic done;
  logic [DATA_W-1:0] read_value;
  logic [DATA_W-1:0] port_rdata;
  logic [DATA_W-1:0] cmd_merged;
  logic [TADDR_W-1:0] stepped;
  sfia_step_t step_kind;
  logic busy;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic sfia_sel_t reg_select(input logic [APB_ADDR_W-1:0] addr);
    sfia_sel_t s;
    if (addr == OFF_DATA) begin
      s = SEL_DATA;
    end else if (addr == OFF_COMMAND) begin
      s = SEL_COMMAND;
    end else begin
      s = SEL_NONE;
    end
    return s;
  endfunction

  function automatic logic [DATA_W-1:0] strobe_merge(
    input logic [DATA_W-1:0] old_value,
    input logic [DATA_W-1:0] new_value,
    input logic [BE_W-1:0] strb
  );
    logic [DATA_W-1:0] r;
    r = old_value;
    for (int i = 0; i < BE_W; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_value[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [TADDR_W-1:0] step_address(
    input logic [TADDR_W-1:0] addr,
    input sfia_step_t kind
  );
    logic [TADDR_W-1:0] r;
    case (kind)
      STEP_UP: r = addr + TADDR_ONE;
      STEP_DOWN: r = addr - TADDR_ONE;
      default: r = addr;
    endcase
    return r;
  endfunction

  // Reserved bits 27:20 are never stored, so they read as zero.
  function automatic logic [DATA_W-1:0] command_word(input sfia_top_state_t s);
    logic [DATA_W-1:0] w;
    w = DATA_RST;
    w[BUSY_BIT] = (s.eng == ENG_BUSY);
    w[DIR_BIT] = s.direction_select;
    w[STEP_UP_BIT] = s.address_step_up;
    w[STEP_DOWN_BIT] = s.address_step_down;
    w[BE_LSB +: BE_W] = s.byte_lane_enables;
    w[TADDR_LSB +: TADDR_W] = s.target_address;
    return w;
  endfunction

  // ---------------------------------------------------------------
  // Register read path
  // ---------------------------------------------------------------
  always_comb begin
    sel = reg_select(apb_req.paddr);
    addr_hit = (sel != SEL_NONE);
    read_value = DATA_RST;
    if (sel == SEL_DATA) begin
      read_value = st.direction_select ? st.fabric_value : st.host_value;
    end else if (sel == SEL_COMMAND) begin
      read_value = command_word(st);
    end
  end

  // ---------------------------------------------------------------
  // Command engine
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    launch = '0;
    busy = (st.eng == ENG_BUSY);
    cmd_merged = strobe_merge(command_word(st), apb_req.pwdata, apb_req.pstrb);
    // Step-up outranks step-down when both are set.
    if (st.address_step_up) begin
      step_kind = STEP_UP;
    end else if (st.address_step_down) begin
      step_kind = STEP_DOWN;
    end else begin
      step_kind = STEP_NONE;
    end
    stepped = step_address(st.target_address, step_kind);

    // Completion: the fabric value and the busy clear land on the same edge.
    if (busy && done) begin
      next_st.eng = ENG_IDLE;
      if (st.direction_select == DIR_READ) begin
        next_st.fabric_value = port_rdata;
      end
      next_st.target_address = step_address(st.target_address, st.pending_step);
      next_st.pending_step = STEP_NONE;
    end

    // While busy the host is expected to keep off, so accesses then have no effect.
    if (commit && !busy) begin
      if (apb_req.pwrite) begin
        if (sel == SEL_DATA) begin
          next_st.host_value = strobe_merge(st.host_value, apb_req.pwdata, apb_req.pstrb);
          if (step_kind != STEP_NONE && st.direction_select == DIR_WRITE) begin
            launch.valid = 1'b1;
            launch.write = 1'b1;
            launch.addr = st.target_address;
            launch.be = st.byte_lane_enables;
            launch.wdata = next_st.host_value;
            next_st.pending_step = step_kind;
            next_st.eng = ENG_BUSY;
          end
        end else if (sel == SEL_COMMAND) begin
          next_st.direction_select = cmd_merged[DIR_BIT];
          next_st.address_step_up = cmd_merged[STEP_UP_BIT];
          next_st.address_step_down = cmd_merged[STEP_DOWN_BIT];
          next_st.byte_lane_enables = cmd_merged[BE_LSB +: BE_W];
          next_st.target_address = cmd_merged[TADDR_LSB +: TADDR_W];
          if (cmd_merged[BUSY_BIT]) begin
            launch.valid = 1'b1;
            launch.write = (cmd_merged[DIR_BIT] == DIR_WRITE);
            launch.addr = cmd_merged[TADDR_LSB +: TADDR_W];
            launch.be = cmd_merged[BE_LSB +: BE_W];
            launch.wdata = st.host_value;
            next_st.pending_step = STEP_NONE;
            next_st.eng = ENG_BUSY;
          end
        end
      end else if (sel == SEL_DATA && st.direction_select == DIR_READ &&
                   step_kind != STEP_NONE) begin
        // The reader already took the old value; fetch the neighbour now.
        next_st.target_address = stepped;
        launch.valid = 1'b1;
        launch.write = 1'b0;
        launch.addr = stepped;
        launch.be = st.byte_lane_enables;
        launch.wdata = st.host_value;
        next_st.pending_step = STEP_NONE;
        next_st.eng = ENG_BUSY;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.host_value <= DATA_RST;
      st.fabric_value <= DATA_RST;
      st.eng <= ENG_IDLE;
      st.direction_select <= DIR_WRITE;
      st.address_step_up <= FLAG_RST;
      st.address_step_down <= FLAG_RST;
      st.byte_lane_enables <= BE_RST;
      st.target_address <= TADDR_RST;
      st.pending_step <= STEP_NONE;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Bus slave and fabric port
  // ---------------------------------------------------------------
  sfia_apb_slave i_sfia_apb_slave (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .addr_hit(addr_hit),
    .read_value(read_value),
    .commit(commit)
  );

  sfia_fabric_port i_sfia_fabric_port (
    .pclk(pclk),
    .presetn(presetn),
    .launch(launch),
    .fab_req(fab_req),
    .fab_rsp(fab_rsp),
    .done(done),
    .read_data(port_rdata)
  );

endmodule

// ---- testbench/sfia_assertions.sv ----
`timescale 1ns/1ps
module sfia_checker (
  input wire logic pclk,
  input wire logic presetn,
  input sfia_pkg::sfia_apb_req_t apb_req,
  input sfia_pkg::sfia_apb_rsp_t apb_rsp,
  input sfia_pkg::sfia_fab_req_t fab_req,
  input sfia_pkg::sfia_fab_rsp_t fab_rsp
);
  import sfia_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // Handshake checks
  // ------------------------------------------------------------
  wire logic setup = apb_req.psel && !apb_req.penable;
  wire logic cmd_go = apb_rsp.pready && apb_req.pwrite && apb_req.paddr == OFF_COMMAND &&
    apb_req.pwdata[BUSY_BIT] && apb_req.pstrb[BE_W-1];
  wire logic unmapped = apb_req.paddr != OFF_DATA && apb_req.paddr != OFF_COMMAND;
  a_ready_after_setup: assert property (setup |=> apb_rsp.pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready longer than one cycle");
  a_ready_in_access: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
    else $error("ready outside access");
  a_unmapped_refused: assert property (setup && unmapped |=>
    apb_rsp.pslverr && apb_rsp.prdata == '0)
    else $error("unmapped access not refused");
  // Three idle cycles of valid guarantee busy has cleared before the commit.
  a_cmd_launch: assert property (cmd_go && !fab_req.valid && !$past(fab_req.valid) &&
    !$past(fab_req.valid, 2) |=> fab_req.valid &&
    fab_req.write == !$past(apb_req.pwdata[DIR_BIT]) &&
    fab_req.addr == $past(apb_req.pwdata[TADDR_LSB +: TADDR_W]) &&
    fab_req.be == $past(apb_req.pwdata[BE_LSB +: BE_W]))
    else $error("command write did not launch");
  a_valid_holds: assert property (fab_req.valid && !fab_rsp.ack |=> fab_req.valid && $stable(fab_req))
    else $error("fabric request changed before ack");
  a_valid_drops: assert property (fab_req.valid && fab_rsp.ack |=> !fab_req.valid)
    else $error("fabric request kept after ack");
  a_launch_cause: assert property ($rose(fab_req.valid) |->
    $past(apb_rsp.pready) || $past(apb_rsp.pready, 2))
    else $error("launch without host access");
  c_cmd_go: cover property (cmd_go);
  c_read_ack: cover property (fab_req.valid && fab_rsp.ack && !fab_req.write);
  c_step_read: cover property ($rose(fab_req.valid) && !$past(apb_req.pwrite));
endmodule
bind sfia_top sfia_checker i_sfia_checker (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .fab_req(fab_req), .fab_rsp(fab_rsp));

// ---- testbench/sfia_fabric_model.sv ----
`timescale 1ns/1ps
module sfia_fabric_model (
  input wire logic pclk,
  input wire logic presetn,
  input sfia_pkg::sfia_fab_req_t fab_req,
  output sfia_pkg::sfia_fab_rsp_t fab_rsp,
  input wire logic [3:0] lat
);
  import sfia_pkg::*;
  logic [31:0] mem [16];
  logic [3:0] cnt;
  logic ack;
  logic hold;
  logic [31:0] rd;
  // Outside the ack cycle the read bus shows junk, never the last value.
  assign fab_rsp = '{ack: ack, rdata: (ack ? rd : ~rd)};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      ack <= 1'h0;
      hold <= 1'h0;
      rd <= 32'h0;
      foreach (mem[i]) mem[i] <= 32'h0;
    end else begin
      ack <= 1'h0;
      if (!fab_req.valid) begin
        hold <= 1'h0;
      end else if (!hold && !ack) begin
        if (cnt < lat) begin
          cnt <= cnt + 4'h1;
        end else begin
          cnt <= 4'h0;
          ack <= 1'h1;
          hold <= 1'h1;
          rd <= mem[fab_req.addr[3:0]];
          for (int b = 0; b < 4; b++) begin
            if (fab_req.write && fab_req.be[b]) begin
              mem[fab_req.addr[3:0]][8*b+:8] <= fab_req.wdata[8*b+:8];
            end
          end
        end
      end
    end
  end
endmodule

// ---- testbench/test_sfia_top.sv ----
`timescale 1ns/1ps
module test_sfia_top;
  import sfia_pkg::*;
  typedef struct {
    logic [15:0] a;
    logic [3:0] be;
    logic [31:0] v;
    logic [31:0] x;
  } sfia_row_t;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic [3:0] lat = 4'h0;
  logic [3:0] strb = 4'hF;
  sfia_apb_req_t req = '0;
  sfia_apb_rsp_t rsp;
  sfia_fab_req_t fq;
  sfia_fab_rsp_t fr;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] r;
  logic e;
  sfia_row_t rows [4] = '{'{16'h0003, 4'hF, 32'h1234_5678, 32'h1234_5678},
    '{16'h0003, 4'h5, 32'hAABB_CCDD, 32'h12BB_56DD}, '{16'h0003, 4'hA, 32'h0, 32'h00BB_00DD},
    '{16'hFFFF, 4'h8, 32'h9900_FFFF, 32'h9900_0000}};
  always #5 pclk = ~pclk;
  sfia_top i_sfia_top (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .fab_req(fq), .fab_rsp(fr));
  sfia_fabric_model i_sfia_fabric_model (.pclk(pclk), .presetn(presetn), .fab_req(fq),
    .fab_rsp(fr), .lat(lat));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task summarize;
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, g, x);
    end
  endtask
  // Pready is taken at the rising edge that ends the access, the same edge the slave commits on.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: d, pstrb: strb};
    @(posedge pclk);
    req.penable <= 1'h1;
    do @(posedge pclk); while (rsp.pready !== 1'h1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask
  task idle;
    int n;
    n = 0;
    do begin
      apb(1'h0, OFF_COMMAND, 32'h0);
      n++;
    end while (r[31] !== 1'h0 && n < 40);
  endtask
  function automatic logic [31:0] cmd(logic go, logic rd, logic [1:0] st, logic [3:0] be,
    logic [15:0] a);
    return {go, rd, st, 8'hFF, be, a};
  endfunction
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      $display("ERROR %0t timeout", $time);
      summarize();
    end
  end
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, OFF_DATA, 32'h0); chk(r, DATA_RST);
    apb(1'h0, OFF_COMMAND, 32'h0); chk(r, 32'h0);
    apb(1'h0, 12'h1B4, 32'h0); chk({e, r[30:0]}, 32'h8000_0000);
    foreach (rows[i]) begin
      apb(1'h1, OFF_DATA, rows[i].v);
      apb(1'h1, OFF_COMMAND, cmd(1'h1, 1'h0, 2'h0, rows[i].be, rows[i].a));
      idle;
      apb(1'h0, OFF_DATA, 32'h0); chk(r, rows[i].v);
      apb(1'h1, OFF_COMMAND, cmd(1'h1, 1'h1, 2'h0, rows[i].be, rows[i].a));
      idle; chk(r, {12'h400, rows[i].be, rows[i].a});
      apb(1'h0, OFF_DATA, 32'h0); chk(r, rows[i].x);
    end
    apb(1'h1, OFF_COMMAND, cmd(1'h0, 1'h0, 2'h2, 4'hF, 16'h0004));
    apb(1'h1, OFF_DATA, 32'h11); idle;
    apb(1'h1, OFF_DATA, 32'h22); idle; chk(r, 32'h200F_0006);
    apb(1'h1, OFF_COMMAND, cmd(1'h0, 1'h0, 2'h3, 4'hF, 16'h0006));
    apb(1'h1, OFF_DATA, 32'h33); idle; chk(r, 32'h300F_0007);
    apb(1'h1, OFF_COMMAND, cmd(1'h0, 1'h0, 2'h1, 4'hF, 16'h0007));
    apb(1'h1, OFF_DATA, 32'h44); idle; chk(r, 32'h100F_0006);
    apb(1'h1, OFF_COMMAND, cmd(1'h1, 1'h1, 2'h2, 4'hF, 16'h0004)); idle;
    apb(1'h0, OFF_DATA, 32'h0); chk(r, 32'h11);
    idle;
    apb(1'h0, OFF_DATA, 32'h0); chk(r, 32'h22);
    idle; chk(r, 32'h600F_0006);
    apb(1'h1, OFF_COMMAND, cmd(1'h1, 1'h1, 2'h1, 4'hF, 16'h0007)); idle;
    apb(1'h0, OFF_DATA, 32'h0); chk(r, 32'h44);
    idle;
    apb(1'h0, OFF_DATA, 32'h0); chk(r, 32'h33);
    idle; chk(r, 32'h500F_0005);
    apb(1'h1, OFF_COMMAND, cmd(1'h0, 1'h1, 2'h0, 4'hF, 16'h0005));
    apb(1'h0, OFF_DATA, 32'h0); chk(r, 32'h22);
    apb(1'h0, OFF_COMMAND, 32'h0); chk(r, 32'h400F_0005);
    lat <= 4'hF;
    apb(1'h1, OFF_COMMAND, cmd(1'h1, 1'h1, 2'h0, 4'hF, 16'h0003));
    apb(1'h1, OFF_COMMAND, cmd(1'h0, 1'h0, 2'h0, 4'hF, 16'h0009));
    apb(1'h1, OFF_DATA, 32'hDEAD_BEEF);
    apb(1'h0, OFF_COMMAND, 32'h0); chk(r, 32'hC00F_0003);
    idle; chk(r, 32'h400F_0003);
    apb(1'h0, OFF_DATA, 32'h0); chk(r, 32'h00BB_00DD);
    apb(1'h1, OFF_COMMAND, cmd(1'h0, 1'h0, 2'h0, 4'hF, 16'h0003));
    apb(1'h1, OFF_DATA, 32'h1111_1111);
    strb <= 4'h3;
    apb(1'h1, OFF_DATA, 32'hAAAA_BBBB);
    strb <= 4'hF;
    apb(1'h0, OFF_DATA, 32'h0); chk(r, 32'h1111_BBBB);
    // A reset in mid-run must clear the host value and every command field.
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, OFF_DATA, 32'h0); chk(r, DATA_RST);
    apb(1'h0, OFF_COMMAND, 32'h0); chk(r, 32'h0);
    summarize();
  end
endmodule
